// File: test/tb_top.sv
// Self-checking bench for the serial port control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic tx_timer_ovf = 1'b0;
  logic rx_timer_ovf = 1'b0;
  logic port_irq_en = 1'b0;
  logic [7:0] sfr_rdata;
  logic rx_timer_reload, rx_pin, tx_pin, port_irq;
  logic [2:0] tx_cnt = 3'h0;
  logic [2:0] rx_cnt = 3'h0;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 32'h5845;
  logic [9:0] got;
  logic [7:0] ctl, dat;
  logic [7:0] latch = 8'h00;
  logic md, tb9, mce, ren, b, rif;
  // Mode, filter, enable, ninth or stop bit, flag preset
  logic [4:0] cs [9] = '{5'h1c, 5'h1e, 5'h14, 5'h1c, 5'h0c, 5'h0e, 5'h04, 5'h12, 5'h15};
  always #20 core_clk = ~core_clk;
  // Overflow every eight cycles; receive copy restarts on a start edge
  always @(posedge core_clk) begin
    tx_cnt <= tx_cnt + 3'h1;
    rx_cnt <= rx_timer_reload ? 3'h0 : rx_cnt + 3'h1;
    tx_timer_ovf <= (tx_cnt == 3'h7);
    rx_timer_ovf <= (rx_cnt == 3'h7) && !rx_timer_reload;
  end
  umc_uart dut (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .tx_timer_ovf(tx_timer_ovf), .rx_timer_ovf(rx_timer_ovf),
    .rx_timer_reload(rx_timer_reload), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .port_irq_en(port_irq_en), .port_irq(port_irq));
  umc_peer peer (.core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [9:0] d);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    // Registered read data stands in the cycle after the strobe
    @(posedge core_clk);
    d = {2'b00, sfr_rdata};
  endtask : rd
  task automatic stop_test;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (12000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    port_irq_en <= 1'b1;
    @(posedge core_clk);
    rd(umc_pkg::CTRL_ADDR, got);
    chk(got, {2'b00, umc_pkg::CTRL_RESET});
    wr(umc_pkg::CTRL_ADDR, 8'hbc);
    rd(umc_pkg::CTRL_ADDR, got);
    chk(got, 10'h0fc);
    rd(8'h9a, got);
    chk(got, 10'h000);
    $display("registers done");
    for (int i = 0; i < 3; i++) begin
      md = (i != 0);
      tb9 = (i == 1);
      ctl = {md, 3'h0, tb9, 3'h0};
      wr(umc_pkg::CTRL_ADDR, ctl);
      dat = 8'($random(seed));
      fork
        peer.grab(md ? 10 : 9, got);
        wr(umc_pkg::DATA_ADDR, dat);
      join
      chk(got, md ? {1'b1, tb9, dat} : {2'b01, dat});
      rd(umc_pkg::CTRL_ADDR, got);
      chk(got, {2'b00, ctl | 8'h42});
      chk({9'h000, port_irq}, 10'h001);
      port_irq_en <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({9'h000, port_irq}, 10'h000);
      port_irq_en <= 1'b1;
      $display("transmit %0d done", i);
    end
    for (int i = 0; i < 9; i++) begin
      {md, mce, ren, b, rif} = cs[i];
      ctl = {md, 1'b0, mce, ren, 3'h0, rif};
      wr(umc_pkg::CTRL_ADDR, ctl);
      dat = 8'($random(seed));
      peer.send({md, b, dat}, md ? 10 : 9);
      if (ren && !rif && (!mce || b)) begin
        latch = dat;
        ctl = ctl | {5'h00, b, 2'b01};
      end
      rd(umc_pkg::CTRL_ADDR, got);
      chk(got, {2'b00, ctl | 8'h40});
      rd(umc_pkg::DATA_ADDR, got);
      chk(got, {2'b00, latch});
      $display("receive %0d done", i);
    end
    stop_test();
  end
endmodule : tb_top
bind umc_uart umc_chk chk_i (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .tx_timer_ovf(tx_timer_ovf), .rx_timer_ovf(rx_timer_ovf),
  .rx_timer_reload(rx_timer_reload), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .port_irq_en(port_irq_en), .port_irq(port_irq));

// File: test/umc_peer.sv
// Far-end serial port: sends frames to the block and decodes its output
module umc_peer (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic tx_pin,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Two timer overflows of eight cycles per bit
  localparam int BIT_CYC = 16;
  initial rx_pin = 1'b1;
  // Start, bits LSB first, ninth bit one for address; idles high
  task automatic send(input logic [9:0] f, input int n);
    rx_pin <= 1'b0;
    repeat (BIT_CYC) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rx_pin <= f[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    rx_pin <= 1'b1;
  endtask : send
  // Samples mid-bit, stop bit included
  task automatic grab(input int n, output logic [9:0] d);
    d = 10'h000;
    @(negedge tx_pin);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      d[i] = tx_pin;
    end
  endtask : grab
endmodule : umc_peer

// File: test/umc_uart_properties.sv
// Port-level assertions for the serial port control block
module umc_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Timers, pins, interrupt
  input wire logic tx_timer_ovf,
  input wire logic rx_timer_ovf,
  input wire logic rx_timer_reload,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic port_irq_en,
  input wire logic port_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  rd_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");
  ctrl_bit6_a: assert property (sfr_rd && sfr_addr == umc_pkg::CTRL_ADDR |=> sfr_rdata[6])
    else $error("control bit 6 read low");
  unmapped_rd_a: assert property (sfr_rd && sfr_addr != umc_pkg::CTRL_ADDR
    && sfr_addr != umc_pkg::DATA_ADDR |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  reload_pulse_a: assert property (rx_timer_reload |=> !rx_timer_reload)
    else $error("reload longer than one cycle");
  reload_cause_a: assert property (rx_timer_reload |->
    !$past(rx_pin, 2) || !$past(rx_pin, 3) || !$past(rx_pin, 4))
    else $error("reload without start edge");
  tx_on_tick_a: assert property (!$stable(tx_pin) |->
    $past(tx_timer_ovf) || $past(tx_timer_ovf, 2) || $past(tx_timer_ovf, 3))
    else $error("serial output moved off a tick");
  irq_mask_a: assert property (!port_irq_en |=> !port_irq)
    else $error("interrupt while disabled");
  irq_rise_a: assert property ($rose(port_irq) |-> $past(port_irq_en))
    else $error("interrupt rose while disabled");
  irq_reset_a: assert property ($fell(reset) |-> !port_irq)
    else $error("interrupt right after reset");
endmodule : umc_chk

// File: verilog/umc_pkg.sv
// Constants shared by the serial port control block
package umc_pkg;
  // Register addresses on the special-function bus
  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Control register field positions
  localparam int MODE_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int MPE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB9_BIT = 3;
  localparam int RB9_BIT = 2;
  localparam int TIF_BIT = 1;
  localparam int RIF_BIT = 0;
  // Timing: one bit lasts two timer overflows; receive samples mid-bit
  localparam logic [1:0] OVF_PER_BIT = 2'h2;
  localparam logic [3:0] DATA_BITS = 4'h8;
endpackage : umc_pkg

// File: verilog/umc_uart.sv
// Serial port with 8/9-bit frames, multiprocessor address filter and control register
module umc_uart (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Baud timer overflows
  input wire logic tx_timer_ovf,
  input wire logic rx_timer_ovf,
  output logic rx_timer_reload,
  // Serial pins
  input wire logic rx_pin,
  output logic tx_pin,
  // Interrupt request to the core
  input wire logic port_irq_en,
  output logic port_irq
);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} umc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} umc_rx_state_t;

  logic frame_mode_select_r;
  logic multiprocessor_enable_r;
  logic receive_enable_r;
  logic ninth_transmit_bit_r;
  logic ninth_receive_bit_r;
  logic transmit_done_flag_r;
  logic receive_done_flag_r;
  logic [7:0] rx_latch_r;
  logic [7:0] ctrl_view;

  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;

  umc_tx_state_t tx_state_r;
  logic [8:0] tx_shift_r;
  logic [3:0] tx_count_r;
  logic tx_half_r;
  logic tx_done_evt;

  umc_rx_state_t rx_state_r;
  logic [8:0] rx_shift_r;
  logic [3:0] rx_count_r;
  logic rx_half_r;
  logic rx_accept;
  logic rx_stop_evt;

  logic wr_ctrl;
  logic wr_data;
  logic tx_tick;
  logic rx_tick;
  logic [3:0] last_bit;

  assign wr_ctrl = sfr_wr && (sfr_addr == umc_pkg::CTRL_ADDR);
  assign wr_data = sfr_wr && (sfr_addr == umc_pkg::DATA_ADDR);

  // Index of the last data bit counted in a frame
  assign last_bit = frame_mode_select_r ? umc_pkg::DATA_BITS : umc_pkg::DATA_BITS - 4'h1;

  // Bit 6 is a constant one in the read view
  always_comb begin
    ctrl_view = {frame_mode_select_r, 1'b1, multiprocessor_enable_r, receive_enable_r,
                 ninth_transmit_bit_r, ninth_receive_bit_r, transmit_done_flag_r,
                 receive_done_flag_r};
  end

  // Control bits that only software writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_mode_select_r <= umc_pkg::CTRL_RESET[umc_pkg::MODE_BIT];
      multiprocessor_enable_r <= umc_pkg::CTRL_RESET[umc_pkg::MPE_BIT];
      receive_enable_r <= umc_pkg::CTRL_RESET[umc_pkg::REN_BIT];
      ninth_transmit_bit_r <= umc_pkg::CTRL_RESET[umc_pkg::TB9_BIT];
    end else if (wr_ctrl) begin
      frame_mode_select_r <= sfr_wdata[umc_pkg::MODE_BIT];
      multiprocessor_enable_r <= sfr_wdata[umc_pkg::MPE_BIT];
      receive_enable_r <= sfr_wdata[umc_pkg::REN_BIT];
      ninth_transmit_bit_r <= sfr_wdata[umc_pkg::TB9_BIT];
    end
  end

  // Transmit flag: a hardware set in the same cycle as a software write wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      transmit_done_flag_r <= umc_pkg::CTRL_RESET[umc_pkg::TIF_BIT];
    end else if (tx_done_evt) begin
      transmit_done_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      transmit_done_flag_r <= sfr_wdata[umc_pkg::TIF_BIT];
    end
  end

  // Receive flag and ninth bit; an accepted frame beats a same-cycle write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      receive_done_flag_r <= umc_pkg::CTRL_RESET[umc_pkg::RIF_BIT];
      ninth_receive_bit_r <= umc_pkg::CTRL_RESET[umc_pkg::RB9_BIT];
    end else if (rx_accept) begin
      receive_done_flag_r <= 1'b1;
      ninth_receive_bit_r <= rx_shift_r[8];
    end else if (wr_ctrl) begin
      receive_done_flag_r <= sfr_wdata[umc_pkg::RIF_BIT];
      ninth_receive_bit_r <= sfr_wdata[umc_pkg::RB9_BIT];
    end
  end

  // Receive latch, loaded only on an accepted frame
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_latch_r <= umc_pkg::DATA_RESET;
    end else if (rx_accept) begin
      rx_latch_r <= rx_shift_r[7:0];
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == umc_pkg::CTRL_ADDR) begin
      sfr_rdata <= ctrl_view;
    end else if (sfr_rd && sfr_addr == umc_pkg::DATA_ADDR) begin
      sfr_rdata <= rx_latch_r;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // Interrupt request while either flag is up
  // Registered, so it trails the flags by one cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= port_irq_en && (transmit_done_flag_r || receive_done_flag_r);
    end
  end

  // Receive pin synchroniser and edge history
  // Reset to idle high so reset release cannot fake a start edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  // Each bit spans two overflows
  assign tx_tick = tx_timer_ovf && tx_half_r;
  assign rx_tick = rx_timer_ovf && rx_half_r;

  // Transmit divider runs free; a new frame waits for the next tick
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_half_r <= 1'b0;
    end else if (tx_timer_ovf) begin
      tx_half_r <= ~tx_half_r;
    end
  end

  // Transmitter; a write during a frame restarts it with the new byte
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 9'h1ff;
      tx_count_r <= 4'h0;
      tx_pin <= 1'b1;
      tx_done_evt <= 1'b0;
    end else begin
      tx_done_evt <= 1'b0;
      if (wr_data) begin
        tx_shift_r <= {ninth_transmit_bit_r, sfr_wdata};
        tx_state_r <= TX_START;
        tx_count_r <= 4'h0;
      end else if (tx_tick) begin
        unique case (tx_state_r)
          TX_IDLE: tx_pin <= 1'b1;
          TX_START: begin
            tx_pin <= 1'b0;
            tx_state_r <= TX_DATA;
          end
          TX_DATA: begin
            tx_pin <= tx_shift_r[0];
            tx_shift_r <= {1'b1, tx_shift_r[8:1]};
            tx_count_r <= tx_count_r + 4'h1;
            if (tx_count_r == last_bit) begin
              tx_state_r <= TX_STOP;
            end
          end
          TX_STOP: begin
            // Flag goes up as the stop bit begins in both modes
            tx_pin <= 1'b1;
            tx_done_evt <= 1'b1;
            tx_state_r <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // Frame acceptance test at the stop sample
  // A frame that lands while the flag is still up is dropped whole
  always_comb begin
    rx_accept = 1'b0;
    if (rx_stop_evt && !receive_done_flag_r) begin
      if (!multiprocessor_enable_r) begin
        rx_accept = 1'b1;
      end else begin
        rx_accept = rx_shift_r[8];
      end
    end
  end

  // Receiver; the start edge reloads the receive timer for mid-bit sampling
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_state_r <= RX_IDLE;
      rx_shift_r <= 9'h000;
      rx_count_r <= 4'h0;
      rx_half_r <= 1'b0;
      rx_timer_reload <= 1'b0;
      rx_stop_evt <= 1'b0;
    end else begin
      rx_timer_reload <= 1'b0;
      rx_stop_evt <= 1'b0;
      if (rx_timer_ovf) begin
        rx_half_r <= ~rx_half_r;
      end
      unique case (rx_state_r)
        RX_IDLE: begin
          if (receive_enable_r && rx_prev_r && !rx_sync_r) begin
            rx_timer_reload <= 1'b1;
            rx_half_r <= 1'b0;
            rx_count_r <= 4'h0;
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          // Overflow in the reload cycle is stale: still the old timer count
          if (rx_timer_ovf && !rx_timer_reload) begin
            // Lands mid start bit; data then every second overflow
            rx_half_r <= 1'b0;
            rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_count_r <= rx_count_r + 4'h1;
            if (frame_mode_select_r) begin
              rx_shift_r <= {rx_sync_r, rx_shift_r[8:1]};
            end else begin
              rx_shift_r <= {1'b0, rx_sync_r, rx_shift_r[7:1]};
            end
            if (rx_count_r == last_bit) begin
              rx_state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            // 8-bit mode puts the stop level where the ninth bit sits
            if (!frame_mode_select_r) begin
              rx_shift_r[8] <= rx_sync_r;
            end
            rx_stop_evt <= 1'b1;
            rx_state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule : umc_uart
